// ---- verilog/iopm_pkg.sv ----
// constants and types for the process image mapper
package iopm_pkg;
  // ------------------------------------------------------------
  // image sizes
  // ------------------------------------------------------------
  localparam int unsigned BIT_IMAGE_W  = 64;
  localparam int unsigned WORD_COUNT   = 32;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned CHAN_W       = 32;

  // ------------------------------------------------------------
  // image bit positions
  // ------------------------------------------------------------
  localparam int unsigned GROUP_W      = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned POS_GROUP_B  = 16;
  localparam int unsigned POS_OUT_88   = 8;
  localparam int unsigned POS_OUT_248  = 24;
  localparam int unsigned IN_W_248     = 24;

  localparam logic [BIT_IMAGE_W-1:0] BIT_IMAGE_RST = 64'h0000_0000_0000_0000;
  localparam logic [CHAN_W-1:0]      CHAN_RST      = 32'h0000_0000;
  localparam logic [WORD_W-1:0]      WORD_RST      = 16'h0000;

  // ------------------------------------------------------------
  // module variants
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    IOPM_IN16    = 3'h0,
    IOPM_IN32    = 3'h1,
    IOPM_OUT16   = 3'h2,
    IOPM_OUT32   = 3'h3,
    IOPM_IO1616  = 3'h4,
    IOPM_IO0808  = 3'h5,
    IOPM_IO2408  = 3'h6
  } iopm_variant_t;
endpackage

// ---- verilog/iopm_out_sel.sv ----
// selects output image bits to output channels per variant
`timescale 1ns/1ps
`default_nettype none
module iopm_out_sel (
  input  wire logic [2:0]  variant,
  input  wire logic [63:0] out_image,
  output logic      [31:0] chan_next
);
  always_comb begin
    chan_next = iopm_pkg::CHAN_RST;
    unique case (variant)
      iopm_pkg::IOPM_OUT16: begin
        chan_next[iopm_pkg::GROUP_W-1:0] = out_image[iopm_pkg::GROUP_W-1:0];
      end
      iopm_pkg::IOPM_OUT32: begin
        chan_next = out_image[iopm_pkg::CHAN_W-1:0];
      end
      iopm_pkg::IOPM_IO1616: begin
        chan_next[iopm_pkg::GROUP_W-1:0] =
          out_image[iopm_pkg::POS_GROUP_B +: iopm_pkg::GROUP_W];
      end
      iopm_pkg::IOPM_IO0808: begin
        chan_next[iopm_pkg::BYTE_W-1:0] =
          out_image[iopm_pkg::POS_OUT_88 +: iopm_pkg::BYTE_W];
      end
      iopm_pkg::IOPM_IO2408: begin
        chan_next[iopm_pkg::BYTE_W-1:0] =
          out_image[iopm_pkg::POS_OUT_248 +: iopm_pkg::BYTE_W];
      end
      // input-only and illegal codes drive nothing
      default: begin
        chan_next = iopm_pkg::CHAN_RST;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- verilog/iopm_mapper.sv ----
// process image mapper between fieldbus images and field channels
//
// Overview of operation
// - sixteen-input variant: inputs 0-15 onto input image bits 0-15
// - thirty-two-input variant: group a on bits 0-15, group b on 16-31
// - sixteen-output variant: output image bits 0-15 drive outputs 0-15
// - thirty-two-output variant: bits 0-15 group a, bits 16-31 group b
// - 16/16 variant: inputs on bits 0-15, outputs from bits 16-31
// - 8/8 variant: inputs on bits 0-7, outputs from bits 8-15
// - 24/8 variant: inputs on bits 0-23, outputs from bits 24-31
// - input and output bit images are each 64 bits wide
// - word images hold 32 sixteen-bit words, unused by digital variants
`timescale 1ns/1ps
`default_nettype none
module iopm_mapper (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [2:0]   variant,
  input  wire logic [15:0]  input_group_a,
  input  wire logic [15:0]  input_group_b,
  input  wire logic [63:0]  output_image_bit,
  input  wire logic [511:0] output_word_image,
  output logic      [63:0]  input_image_bit,
  output logic      [511:0] input_word_image,
  output logic      [15:0]  output_group_a,
  output logic      [15:0]  output_group_b
);
  // ------------------------------------------------------------
  // input image areas in use
  // ------------------------------------------------------------
  // a second, independent table: a slip in the channel case below still
  // cannot light a reserved bit that the master reads
  logic [63:0] in_used;

  always_comb begin
    in_used = iopm_pkg::BIT_IMAGE_RST;
    unique case (variant)
      iopm_pkg::IOPM_IN16: begin
        in_used[iopm_pkg::GROUP_W-1:0] = '1;
      end
      iopm_pkg::IOPM_IN32: begin
        in_used[iopm_pkg::CHAN_W-1:0] = '1;
      end
      iopm_pkg::IOPM_IO1616: begin
        in_used[iopm_pkg::GROUP_W-1:0] = '1;
      end
      iopm_pkg::IOPM_IO0808: begin
        in_used[iopm_pkg::BYTE_W-1:0] = '1;
      end
      iopm_pkg::IOPM_IO2408: begin
        in_used[iopm_pkg::IN_W_248-1:0] = '1;
      end
      // output-only and illegal codes report nothing
      default: begin
        in_used = iopm_pkg::BIT_IMAGE_RST;
      end
    endcase
  end

  // ------------------------------------------------------------
  // input image
  // ------------------------------------------------------------
  logic      [63:0] in_image;
  logic      [63:0] next_in_image;
  wire logic [31:0] in_chan;

  // group b above group a
  // per-channel wiring keeps the pairing of field pin and image bit explicit
  genvar ci;
  generate
    for (ci = 0; ci < iopm_pkg::GROUP_W; ci++) begin : g_chan
      assign in_chan[ci]                         = input_group_a[ci];
      assign in_chan[iopm_pkg::POS_GROUP_B + ci] = input_group_b[ci];
    end
  endgenerate

  always_comb begin
    next_in_image = iopm_pkg::BIT_IMAGE_RST;
    unique case (variant)
      iopm_pkg::IOPM_IN16: begin
        next_in_image[iopm_pkg::GROUP_W-1:0] = input_group_a;
      end
      iopm_pkg::IOPM_IO1616: begin
        next_in_image[iopm_pkg::GROUP_W-1:0] = input_group_a;
      end
      iopm_pkg::IOPM_IN32: begin
        next_in_image[iopm_pkg::CHAN_W-1:0] = in_chan;
      end
      iopm_pkg::IOPM_IO0808: begin
        next_in_image[iopm_pkg::BYTE_W-1:0] = input_group_a[iopm_pkg::BYTE_W-1:0];
      end
      iopm_pkg::IOPM_IO2408: begin
        next_in_image[iopm_pkg::IN_W_248-1:0] = in_chan[iopm_pkg::IN_W_248-1:0];
      end
      // output-only and illegal codes report nothing
      default: begin
        next_in_image = iopm_pkg::BIT_IMAGE_RST;
      end
    endcase
    next_in_image = next_in_image & in_used;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_image <= iopm_pkg::BIT_IMAGE_RST;
    end else if (clk_en) begin
      in_image <= next_in_image;
    end
  end

  assign input_image_bit = in_image;

  // ------------------------------------------------------------
  // output image areas in use
  // ------------------------------------------------------------
  // masking here as well as in the selector keeps a reserved bit from
  // ever reaching a channel, even if the selector table grows
  logic [63:0] out_used;
  logic [63:0] out_masked;

  always_comb begin
    out_used = iopm_pkg::BIT_IMAGE_RST;
    unique case (variant)
      iopm_pkg::IOPM_OUT16: begin
        out_used[iopm_pkg::GROUP_W-1:0] = '1;
      end
      iopm_pkg::IOPM_OUT32: begin
        out_used[iopm_pkg::CHAN_W-1:0] = '1;
      end
      iopm_pkg::IOPM_IO1616: begin
        out_used[iopm_pkg::POS_GROUP_B +: iopm_pkg::GROUP_W] = '1;
      end
      iopm_pkg::IOPM_IO0808: begin
        out_used[iopm_pkg::POS_OUT_88 +: iopm_pkg::BYTE_W] = '1;
      end
      iopm_pkg::IOPM_IO2408: begin
        out_used[iopm_pkg::POS_OUT_248 +: iopm_pkg::BYTE_W] = '1;
      end
      // input-only and illegal codes use no output bit
      default: begin
        out_used = iopm_pkg::BIT_IMAGE_RST;
      end
    endcase
  end

  assign out_masked = output_image_bit & out_used;

  // ------------------------------------------------------------
  // output channels
  // ------------------------------------------------------------
  logic [31:0] out_chan;
  logic [31:0] next_out_chan;

  iopm_out_sel u_out_sel (
    .variant   (variant),
    .out_image (out_masked),
    .chan_next (next_out_chan)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_chan <= iopm_pkg::CHAN_RST;
    end else if (clk_en) begin
      out_chan <= next_out_chan;
    end
  end

  assign output_group_a = out_chan[iopm_pkg::GROUP_W-1:0];
  assign output_group_b = out_chan[iopm_pkg::POS_GROUP_B +: iopm_pkg::GROUP_W];

  // ------------------------------------------------------------
  // word images
  // ------------------------------------------------------------
  // digital variants carry no word data; output words are ignored
  // each entry keeps its own flop so the word port has the same
  // one-cycle timing as the bit image
  wire logic [511:0] in_words;

  genvar gi;
  generate
    for (gi = 0; gi < iopm_pkg::WORD_COUNT; gi++) begin : g_word
      logic [iopm_pkg::WORD_W-1:0] word_q;
      logic [iopm_pkg::WORD_W-1:0] next_word;

      always_comb begin
        next_word = iopm_pkg::WORD_RST;
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          word_q <= iopm_pkg::WORD_RST;
        end else if (clk_en) begin
          word_q <= next_word;
        end
      end

      assign in_words[gi*iopm_pkg::WORD_W +: iopm_pkg::WORD_W] = word_q;
    end
  endgenerate

  assign input_word_image = in_words;

  logic unused_words;
  assign unused_words = ^output_word_image;
endmodule
`default_nettype wire

// ---- tb/iopm_monitor.sv ----
// checker on the mapper ports
`timescale 1ns/1ps
`default_nettype none
module iopm_monitor (
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic         clk_en,
  input wire logic [2:0]   variant,
  input wire logic [15:0]  input_group_a,
  input wire logic [15:0]  input_group_b,
  input wire logic [63:0]  output_image_bit,
  input wire logic [63:0]  input_image_bit,
  input wire logic [511:0] input_word_image,
  input wire logic [15:0]  output_group_a,
  input wire logic [15:0]  output_group_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // sampled reset keeps the release edge, where the flops still clear, out
  sequence took(logic [2:0] v);
    rst_n && clk_en && variant == v;
  endsequence
  in16_map_a: assert property (took(3'h0) |=>
    input_image_bit == {48'h0, $past(input_group_a)}) else $error("in16 map");
  in32_map_a: assert property (took(3'h1) |=>
    input_image_bit == {32'h0, $past({input_group_b, input_group_a})}) else $error("in32 map");
  out16_map_a: assert property (took(3'h2) |=>
    output_group_b == 16'h0 && output_group_a == $past(output_image_bit[15:0]))
    else $error("out16 map");
  out32_map_a: assert property (took(3'h3) |=>
    {output_group_b, output_group_a} == $past(output_image_bit[31:0])) else $error("out32 map");
  io16_map_a: assert property (took(3'h4) |=>
    output_group_a == $past(output_image_bit[31:16])) else $error("io16 map");
  io8_map_a: assert property (took(3'h5) |=>
    output_group_a == {8'h0, $past(output_image_bit[15:8])}) else $error("io8 map");
  io24_map_a: assert property (took(3'h6) |=>
    input_image_bit[63:16] == {40'h0, $past(input_group_b[7:0])}) else $error("io24 map");
  word_zero_a: assert property (input_word_image == 512'h0) else $error("word image");
  io16_in_a: assert property (took(3'h4) |=>
    input_image_bit == {48'h0, $past(input_group_a)} && output_group_b == 16'h0)
    else $error("io16 inputs");
  io8_in_a: assert property (took(3'h5) |=>
    input_image_bit == {56'h0, $past(input_group_a[7:0])}) else $error("io8 inputs");
  in32_quiet_a: assert property (took(3'h1) |=>
    output_group_a == 16'h0 && output_group_b == 16'h0) else $error("in32 outputs");
  bad_code_a: assert property (took(3'h7) |=>
    input_image_bit == 64'h0 && output_group_a == 16'h0 && output_group_b == 16'h0)
    else $error("illegal code");
  hold_frozen_a: assert property (rst_n && !clk_en |=>
    $stable(input_image_bit) && $stable(output_group_a) && $stable(output_group_b))
    else $error("enable low");
endmodule
bind iopm_mapper iopm_monitor mon (.*);
`default_nettype wire

// ---- tb/iopm_master_model.sv ----
// fieldbus master model that writes the output image
`timescale 1ns/1ps
`default_nettype none
module iopm_master_model (
  input wire logic         sys_clk,
  input wire logic [2:0]   variant,
  input wire logic [63:0]  set_img,
  output logic     [63:0]  output_image_bit,
  output logic     [511:0] output_word_image
);
  always_ff @(posedge sys_clk) begin
    output_image_bit <= (variant == 3'h1) ? 64'h0 : set_img;
  end
  // words clear for in32, elsewhere nonzero to expose leaks
  assign output_word_image = (variant == 3'h1) ? {32{16'h0000}} : {32{16'h5A3C}};
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the process image mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         clk_en = 1'b1;
  logic [2:0]   variant = 3'h0;
  logic [15:0]  input_group_a = 16'hA5C3;
  logic [15:0]  input_group_b = 16'h3C96;
  logic [63:0]  set_img = 64'hF0E1_D2C3_B4A5_9687;
  logic [63:0]  output_image_bit, input_image_bit;
  logic [511:0] output_word_image, input_word_image;
  logic [15:0]  output_group_a, output_group_b;
  int           error_cnt = 0, cmp_count = 0, cyc = 0;
  wire logic [95:0] seen = {input_image_bit, output_group_a, output_group_b};
  always #4 sys_clk = ~sys_clk;
  iopm_master_model mdl (.sys_clk(sys_clk), .variant(variant), .set_img(set_img),
    .output_image_bit(output_image_bit), .output_word_image(output_word_image));
  iopm_mapper uut (.*);
  // model register plus mapper register: three edges settle all
  task automatic run(input logic [2:0] v, input logic [95:0] exp);
    @(posedge sys_clk);
    variant <= v;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(seen, exp)
  endtask
  task wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_in16; run(3'h0, 96'hA5C3_0000_0000); endtask
  task t_in32; run(3'h1, 96'h3C96_A5C3_0000_0000); endtask
  task t_out16; run(3'h2, 96'h9687_0000); endtask
  task t_out32; run(3'h3, 96'h9687_B4A5); endtask
  task t_io16; run(3'h4, 96'hA5C3_B4A5_0000); endtask
  task t_io8; run(3'h5, 96'hC3_0096_0000); endtask
  task t_io24; run(3'h6, 96'h96_A5C3_00B4_0000); endtask
  task t_bad; run(3'h7, 96'h0); endtask
  // enable low must freeze the images although the variant moves
  task automatic t_hold;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    variant <= 3'h3;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(seen, 96'h0)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(seen, 96'h9687_B4A5)
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    `CHK(seen, 96'h0)
    rst_n <= 1'b1;
    t_in16;
    t_in32;
    t_out16;
    t_out32;
    t_io16;
    t_io8;
    t_io24;
    t_bad;
    t_hold;
    `CHK(input_word_image, 512'h0)
    wrap_up;
  end
endmodule
`default_nettype wire
